// File: hdl/cg_defines.svh
// Purpose: register map, field positions, codes and reset values
// Assumes: 32-bit apb, one aligned word per register
// Notes:   definitions only
`ifndef CG_DEFINES_SVH
`define CG_DEFINES_SVH
// ****************
// register map
// ****************
`define CG_ADDR_CON0   8'h00
`define CG_ADDR_CON1   8'h04
`define CG_ADDR_SDCTL  8'h08
`define CG_ADDR_SDSRC  8'h0C
`define CG_ADDR_STEER  8'h10
`define CG_ADDR_CNT0   8'h14
`define CG_ADDR_CNTN   8'h28
// ****************
// fields
// ****************
`define CG_EN_BIT      7
`define CG_LD_BIT      6
`define CG_RDBS_BIT    7
`define CG_FDBS_BIT    6
`define CG_FORCE_BIT   7
`define CG_ARS_BIT     6
`define CG_RST_BYTE    8'h00
// ****************
// codes
// ****************
`define CG_CS_FOSC4    2'h0
`define CG_CS_FOSC     2'h1
`define CG_CS_FAST     2'h2
`define CG_MD_STEER    3'h0
`define CG_MD_SYNC     3'h1
`define CG_MD_FWD      3'h2
`define CG_MD_REV      3'h3
`define CG_MD_HALF     3'h4
`define CG_MD_PUSH     3'h5
`define CG_OV_INACT    2'h0
`define CG_OV_LOW      2'h1
`define CG_OV_HIGH     2'h2
`define CG_OV_TRI      2'h3
`define CG_DIV4_LAST   2'h3
`endif

// File: hdl/cg_pkg.sv
// Purpose: shared types
// Assumes: nothing
// Notes:   state codes are gray along off-shut-wait-run
package cg_pkg;
  typedef enum logic [1:0] {
    CG_OFF   = 2'b00,
    CG_SHUT  = 2'b01,
    CG_WAITR = 2'b11,
    CG_RUN   = 2'b10
  } cg_state_e;
  typedef logic [7:0] cg_byte_t;
endpackage

// File: hdl/cg_delay_if.sv
// Purpose: carrier between controller and one delay counter
// Assumes: single clock
// Notes:   done is combinational from the counter
`timescale 1ns/10ps
`default_nettype none
interface cg_delay_if;
  logic       start;
  logic       tick;
  logic [7:0] count;
  logic       done;
  logic       busy;
  modport ctrl  (output start, tick, count, input done, busy);
  modport timer (input start, tick, count, output done, busy);
endinterface
`default_nettype wire

// File: hdl/cg_delay_timer.sv
// Purpose: count of ticks between an event and its delayed copy
// Assumes: tick is a one-cycle enable
// Notes:   a zero count passes the event straight through
`timescale 1ns/10ps
`default_nettype none
module cg_delay_timer
  import cg_pkg::*;
(
  input wire logic   clk,
  input wire logic   reset,
  cg_delay_if.timer  dl
);
  logic [7:0] cnt_reg;
  logic       busy_reg;
  wire        zeroCnt = (dl.count == 8'h00);
  wire        lastTick = busy_reg && dl.tick && (cnt_reg == 8'h01);
  // a new start restarts the count, so the delay always follows the last event
  assign dl.done = (dl.start && zeroCnt) || (lastTick && !dl.start);
  assign dl.busy = busy_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg  <= 8'h00;
      busy_reg <= 1'b0;
    end else if (dl.start) begin
      cnt_reg  <= dl.count;
      busy_reg <= !zeroCnt;
    end else if (lastTick) begin
      busy_reg <= 1'b0;
    end else if (busy_reg && dl.tick) begin
      cnt_reg  <= cnt_reg - 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: hdl/cg_output_ctrl.sv
// Purpose: control, buffering and output stage of the output generator
// Assumes: apb slave, one wait state per transfer; event pins asynchronous
// Notes:   delay chain modelled as steps of clk
// Functional notes
// - control 0 bit 7 turns the generator on, and all control bits reset to zero.
// - control 0 bit 6 requests a count buffer copy on the next event and reads zero when done.
// - counts pass straight to buffers while disabled and wait for the load bit while enabled.
// - control 0 bits 4-3 pick fast oscillator, system clock or a quarter of it.
// - control 0 bits 2-0 pick steered, synced steered, forward, reverse, half bridge or push-pull.
// - control 1 bit 7 times the rising dead band by delay chain or by generator clock.
// - control 1 bit 6 times the falling dead band by delay chain or by generator clock.
// - control 1 bits 3-0 make outputs d, c, b, a active low when set.
// - control 0 bit 5 and control 1 bits 5-4 always read zero.
// - the generator turns its own output drivers off when shutdown asks for it.
// - after enable the generator starts in shutdown driving the override levels.
// - auto-restart clears shutdown force by hardware, or software clears it.
// - after shutdown is released, overrides hold until the first rising event.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "cg_defines.svh"
module cg_output_ctrl
  import cg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        riseIn,
  input  wire logic        fallIn,
  input  wire logic [3:0]  shutIn,
  input  wire logic        fastOscTick,
  output logic      [3:0]  outLevel,
  output logic      [3:0]  outEnable
);
  // ****************
  // registers
  // ****************
  logic             en_reg, ld_reg, rdbs_reg, fdbs_reg;
  logic             force_reg, ars_reg;
  logic [1:0]       cs_reg, ovAc_reg, ovBd_reg, div_reg;
  logic [2:0]       md_reg;
  logic [3:0]       pol_reg, src_reg, steerSync_reg;
  cg_byte_t         steer_reg;
  cg_byte_t         cnt_reg [6];
  cg_byte_t         buf_reg [6];
  cg_state_e        state_reg, state_next;
  logic             pwm_reg, prim_reg, sec_reg, pp_reg;
  logic [5:0]       s1_reg, s2_reg, s3_reg, filt_reg, old_reg;
  logic [31:0]      rdMux;
  logic             hit;
  logic [3:0]       actVec, lvlNext, oeNext;
  // ****************
  // apb decode
  // ****************
  wire        acc     = psel && penable && pready;
  wire        wrAny   = acc && pwrite && hit;
  wire        wrCon0  = wrAny && (paddr == `CG_ADDR_CON0);
  wire        wrCon1  = wrAny && (paddr == `CG_ADDR_CON1);
  wire        wrSd    = wrAny && (paddr == `CG_ADDR_SDCTL);
  wire        wrSrc   = wrAny && (paddr == `CG_ADDR_SDSRC);
  wire        wrSteer = wrAny && (paddr == `CG_ADDR_STEER);
  wire [7:0]  cntOff  = paddr - `CG_ADDR_CNT0;
  wire [2:0]  cntIdx  = cntOff[4:2];
  wire        isCnt   = (paddr >= `CG_ADDR_CNT0) && (paddr <= `CG_ADDR_CNTN);
  wire [7:0]  wb      = pwdata[7:0];
  always_comb begin
    hit   = 1'b1;
    rdMux = 32'h0000_0000;
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (paddr == `CG_ADDR_CON0) begin
      rdMux[7:0] = {en_reg, ld_reg, 1'b0, cs_reg, md_reg};
    end else if (paddr == `CG_ADDR_CON1) begin
      rdMux[7:0] = {rdbs_reg, fdbs_reg, 2'b00, pol_reg};
    end else if (paddr == `CG_ADDR_SDCTL) begin
      rdMux[7:0] = {force_reg, ars_reg, 2'b00, ovBd_reg, ovAc_reg};
    end else if (paddr == `CG_ADDR_SDSRC) begin
      rdMux[7:0] = {4'h0, src_reg};
    end else if (paddr == `CG_ADDR_STEER) begin
      rdMux[7:0] = steer_reg;
    end else if (isCnt) begin
      rdMux[7:0] = cnt_reg[cntIdx];
    end else begin
      hit = 1'b0;
    end
  end
  // one wait state: the answer is prepared in the first access cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rdMux;
      end
    end
  end
  // ****************
  // pin synchronisers
  // ****************
  wire [5:0] pins    = {shutIn, fallIn, riseIn};
  // a level is taken only once the last two stages agree
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg   <= 6'h3C;
      s2_reg   <= 6'h3C;
      s3_reg   <= 6'h3C;
      filt_reg <= 6'h3C;
      old_reg  <= 6'h3C;
    end else begin
      s1_reg   <= pins;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & filt_reg);
      old_reg  <= filt_reg;
    end
  end
  wire riseEdge = filt_reg[0] && !old_reg[0];
  wire fallEdge = filt_reg[1] && !old_reg[1];
  wire srcLow   = |(src_reg & ~filt_reg[5:2]);
  wire sdActive = force_reg || srcLow;
  // ****************
  // generator clock
  // ****************
  wire genTick = (cs_reg == `CG_CS_FOSC)  ? 1'b1 :
                 (cs_reg == `CG_CS_FOSC4) ? (div_reg == `CG_DIV4_LAST) :
                 (cs_reg == `CG_CS_FAST)  ? fastOscTick : 1'b0;
  always_ff @(posedge clk) begin
    if (reset || !en_reg) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end
  // ****************
  // event timers
  // ****************
  // 0 rise phase, 1 fall phase, 2 rise band, 3 fall band, 4 rise blank, 5 fall blank
  cg_delay_if dly [6] ();
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : gTimer
      cg_delay_timer uTimer (
        .clk   (clk),
        .reset (reset),
        .dl    (dly[gi])
      );
      assign dly[gi].count = buf_reg[gi];
    end
  endgenerate
  wire risePh = dly[0].done;
  wire fallPh = dly[1].done;
  assign dly[0].start = en_reg && riseEdge && !dly[5].busy;
  assign dly[1].start = en_reg && fallEdge && !dly[4].busy;
  assign dly[2].start = risePh;
  assign dly[3].start = fallPh;
  assign dly[4].start = risePh;
  assign dly[5].start = fallPh;
  assign dly[0].tick  = genTick;
  assign dly[1].tick  = genTick;
  assign dly[2].tick  = rdbs_reg ? 1'b1 : genTick;
  assign dly[3].tick  = fdbs_reg ? 1'b1 : genTick;
  assign dly[4].tick  = genTick;
  assign dly[5].tick  = genTick;
  // ****************
  // control registers
  // ****************
  wire loadNow = en_reg && ld_reg && risePh;
  always_ff @(posedge clk) begin
    if (reset) begin
      en_reg   <= 1'b0;
      cs_reg   <= 2'h0;
      md_reg   <= 3'h0;
      rdbs_reg <= 1'b0;
      fdbs_reg <= 1'b0;
      pol_reg  <= 4'h0;
      src_reg  <= 4'h0;
      steer_reg <= `CG_RST_BYTE;
      ovAc_reg <= 2'h0;
      ovBd_reg <= 2'h0;
      ars_reg  <= 1'b0;
    end else begin
      if (wrCon0) begin
        en_reg <= wb[`CG_EN_BIT];
        cs_reg <= wb[4:3];
        md_reg <= wb[2:0];
      end
      if (wrCon1) begin
        rdbs_reg <= wb[`CG_RDBS_BIT];
        fdbs_reg <= wb[`CG_FDBS_BIT];
        pol_reg  <= wb[3:0];
      end
      if (wrSd) begin
        ars_reg  <= wb[`CG_ARS_BIT];
        ovBd_reg <= wb[3:2];
        ovAc_reg <= wb[1:0];
      end
      if (wrSrc) begin
        src_reg <= wb[3:0];
      end
      if (wrSteer) begin
        steer_reg <= wb;
      end
    end
  end
  // software writes win over the hardware clears below
  always_ff @(posedge clk) begin
    if (reset) begin
      ld_reg    <= 1'b0;
      force_reg <= 1'b0;
    end else begin
      if (wrCon0) begin
        ld_reg <= wb[`CG_LD_BIT];
      end else if (loadNow || !en_reg) begin
        ld_reg <= 1'b0;
      end
      if (wrSd) begin
        force_reg <= wb[`CG_FORCE_BIT];
      end else if (ars_reg && force_reg && !srcLow) begin
        force_reg <= 1'b0;
      end
    end
  end
  // ****************
  // count buffers
  // ****************
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 6; i++) begin
        cnt_reg[i] <= `CG_RST_BYTE;
        buf_reg[i] <= `CG_RST_BYTE;
      end
    end else begin
      if (wrAny && isCnt) begin
        cnt_reg[cntIdx] <= wb;
      end
      for (int i = 0; i < 6; i++) begin
        if (!en_reg || loadNow) begin
          buf_reg[i] <= cnt_reg[i];
        end
      end
    end
  end
  // ****************
  // sequencing
  // ****************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CG_OFF: begin
        if (en_reg) begin
          state_next = CG_SHUT;
        end
      end
      CG_SHUT: begin
        if (!sdActive) begin
          state_next = CG_WAITR;
        end
      end
      CG_WAITR: begin
        if (sdActive) begin
          state_next = CG_SHUT;
        end else if (risePh) begin
          state_next = CG_RUN;
        end
      end
      default: begin
        if (sdActive) begin
          state_next = CG_SHUT;
        end
      end
    endcase
    if (!en_reg) begin
      state_next = CG_OFF;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= CG_OFF;
    end else begin
      state_reg <= state_next;
    end
  end
  // ****************
  // waveform state
  // ****************
  always_ff @(posedge clk) begin
    if (reset || state_reg == CG_OFF) begin
      pwm_reg       <= 1'b0;
      prim_reg      <= 1'b0;
      sec_reg       <= 1'b0;
      pp_reg        <= 1'b0;
      steerSync_reg <= 4'h0;
    end else begin
      if (risePh) begin
        pwm_reg       <= 1'b1;
        sec_reg       <= 1'b0;
        pp_reg        <= !pp_reg;
        steerSync_reg <= steer_reg[3:0];
      end else if (fallPh) begin
        pwm_reg  <= 1'b0;
        prim_reg <= 1'b0;
      end
      if (dly[2].done) begin
        prim_reg <= 1'b1;
      end
      if (dly[3].done) begin
        sec_reg <= 1'b1;
      end
    end
  end
  // ****************
  // output stage
  // ****************
  always_comb begin
    case (md_reg)
      `CG_MD_STEER: actVec = (steer_reg[3:0] & {4{pwm_reg}}) |
                             (~steer_reg[3:0] & steer_reg[7:4]);
      `CG_MD_SYNC:  actVec = (steerSync_reg & {4{pwm_reg}}) |
                             (~steerSync_reg & steer_reg[7:4]);
      `CG_MD_FWD:   actVec = {pwm_reg, 1'b0, 1'b0, 1'b1};
      `CG_MD_REV:   actVec = {1'b0, 1'b1, pwm_reg, 1'b0};
      `CG_MD_HALF:  actVec = {sec_reg, prim_reg, sec_reg, prim_reg};
      `CG_MD_PUSH:  actVec = {prim_reg && !pp_reg, prim_reg && pp_reg,
                              prim_reg && !pp_reg, prim_reg && pp_reg};
      default:      actVec = 4'h0;
    endcase
  end
  // override for one pin: {enable, level}; forced levels ignore polarity
  function automatic logic [1:0] ovPin(input logic [1:0] code, input logic pol);
    case (code)
      `CG_OV_LOW:  ovPin = 2'b10;
      `CG_OV_HIGH: ovPin = 2'b11;
      `CG_OV_TRI:  ovPin = 2'b00;
      default:     ovPin = {1'b1, pol};
    endcase
  endfunction
  wire [1:0] ovA = ovPin(ovAc_reg, pol_reg[0]);
  wire [1:0] ovB = ovPin(ovBd_reg, pol_reg[1]);
  wire [1:0] ovC = ovPin(ovAc_reg, pol_reg[2]);
  wire [1:0] ovD = ovPin(ovBd_reg, pol_reg[3]);
  always_comb begin
    lvlNext = 4'h0;
    oeNext  = 4'h0;
    if (state_reg == CG_RUN) begin
      lvlNext = actVec ^ pol_reg;
      oeNext  = 4'hF;
    end else if (state_reg != CG_OFF) begin
      lvlNext = {ovD[0], ovC[0], ovB[0], ovA[0]};
      oeNext  = {ovD[1], ovC[1], ovB[1], ovA[1]};
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      outLevel  <= 4'h0;
      outEnable <= 4'h0;
    end else begin
      outLevel  <= lvlNext;
      outEnable <= oeNext;
    end
  end
  // ****************
  // checks
  // ****************
  wire [7:0] bufDbR = buf_reg[2];
  wire [7:0] cntDbR = cnt_reg[2];
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_EN_OFF: assert property ($fell(en_reg) |-> ##2 (outEnable == 4'h0))
    else $error("outputs still driven after disable");
  AST_LD_CLR: assert property (loadNow && !wrCon0 |=> !ld_reg)
    else $error("load bit not cleared after copy");
  AST_BUF_DIS: assert property (!en_reg |=> (bufDbR == $past(cntDbR)))
    else $error("buffer not following count while disabled");
  AST_BUF_HOLD: assert property (en_reg && !ld_reg |=> $stable(bufDbR))
    else $error("buffer changed without load request");
  AST_DIV4: assert property (en_reg && cs_reg == 2'h0 && genTick
    |=> (!genTick || cs_reg != 2'h0) [*3])
    else $error("quarter rate tick too frequent");
  AST_POL: assert property (state_reg == CG_RUN |=> outLevel == $past(actVec ^ pol_reg))
    else $error("output polarity wrong");
  AST_RSV: assert property (pready && !pwrite && paddr == `CG_ADDR_CON1
    |-> prdata[5:4] == 2'b00)
    else $error("unimplemented bits read nonzero");
  AST_TRI: assert property (state_reg == CG_SHUT && ovAc_reg == 2'h3
    |=> outEnable[0] == 1'b0 && outEnable[2] == 1'b0)
    else $error("driver on in tristate override");
  AST_START: assert property ($rose(en_reg) |=> state_reg == CG_SHUT)
    else $error("enable did not start in shutdown");
  AST_ARS: assert property (ars_reg && force_reg && !srcLow && !wrSd |=> !force_reg)
    else $error("auto restart did not clear force");
  AST_SYNC: assert property (state_reg == CG_WAITR && !risePh |=> state_reg != CG_RUN)
    else $error("run started without rising event");
endmodule
`default_nettype wire

// File: bench/cg_drive_stage.sv
// Purpose: power stage model on the far side of the output pins
// Assumes: no pull resistors on the output nets
// Notes:   fault lines are active low towards the generator
`timescale 1ns/10ps
`default_nettype none
module cg_drive_stage (
  input  wire logic [3:0] outLevel,
  input  wire logic [3:0] outEnable,
  input  wire logic [3:0] faultOn,
  output logic      [3:0] pinLevel,
  output logic      [3:0] shutLine
);
  // ****************
  // pin nets
  // ****************
  // an undriven net floats; show the inverse of the held level so it never passes for driven
  assign pinLevel = (outEnable & outLevel) | (~outEnable & ~outLevel);
  assign shutLine = ~faultOn;
endmodule
`default_nettype wire

// File: bench/complementary_output_control_tb_top.sv
// Purpose: self-checking bench of the output generator control
// Assumes: apb answer after one wait state, bounded by the bench anyway
// Notes:   fixed seed, register codes swept in a loop
`timescale 1ns/10ps
`default_nettype none
`include "cg_defines.svh"
module complementary_output_control_tb_top;
  import cg_pkg::*;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr;
  logic        riseIn, fallIn, fastOscTick;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  shutIn, outLevel, outEnable, faultOn, pinLevel;
  logic        err;
  int          failures, checked;

  cg_output_ctrl u_cg_output_ctrl (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .riseIn(riseIn), .fallIn(fallIn), .shutIn(shutIn),
    .fastOscTick(fastOscTick), .outLevel(outLevel), .outEnable(outEnable));
  cg_drive_stage u_cg_drive_stage (.outLevel(outLevel), .outEnable(outEnable),
    .faultOn(faultOn), .pinLevel(pinLevel), .shutLine(shutIn));

  // ****************
  // helpers
  // ****************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 50) begin
      failures++;
      wrap_up();
    end
  endtask
  // a low-to-high edge per event; held long enough to pass the input synchronisers
  // long enough for a three-tick phase delay on the quarter-rate clock
  task automatic pulseEvents(input logic [3:0] act);
    riseIn <= 1'b1;
    repeat (30) @(posedge clk);
    check("active level", {28'h0, outLevel}, {28'h0, act});
    riseIn <= 1'b0; fallIn <= 1'b1;
    repeat (30) @(posedge clk);
    fallIn <= 1'b0;
  endtask
  task automatic waitEnable(input logic [3:0] exp);
    int n;
    n = 0;
    while (outEnable !== exp && n < 40) begin
      @(posedge clk);
      n++;
    end
    check("outEnable", {28'h0, outEnable}, {28'h0, exp});
  endtask
  function automatic logic [31:0] con0Exp(input logic [31:0] v);
    return {24'h0, v[7:0] & 8'hDF};
  endfunction

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    wrap_up();
  end
  always @(posedge clk) fastOscTick <= 1'($urandom);

  // ****************
  // main sequence
  // ****************
  initial begin
    logic [31:0] v;
    int n;
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; riseIn = 1'b0; fallIn = 1'b0; faultOn = 4'h0;
    void'($urandom(34));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, `CG_ADDR_CON0, 32'h0); check("con0 reset", rd, 32'h0);
    apb(1'b0, `CG_ADDR_CON1, 32'h0); check("con1 reset", rd, 32'h0);
    check("outEnable off", {28'h0, outEnable}, 32'h0);
    apb(1'b0, 8'h30, 32'h0); check("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b0, 8'h02, 32'h0); check("unaligned err", {31'h0, err}, 32'h1);
    $display("test reset done");
    // every mode and clock code, unimplemented bits written high at random
    for (int i = 0; i < 8; i++) begin
      v = ($urandom & 32'hFFFF_FF00) | {26'h0, 1'($urandom), 2'(i), 3'(i)};
      apb(1'b1, `CG_ADDR_CON0, v);
      apb(1'b0, `CG_ADDR_CON0, 32'h0); check("con0", rd, con0Exp(v));
      v = $urandom;
      apb(1'b1, `CG_ADDR_CON1, v);
      apb(1'b0, `CG_ADDR_CON1, 32'h0); check("con1", rd, {24'h0, v[7:0] & 8'hCF});
    end
    $display("test fields done");
    // bring-up while disabled: counts, sources, overrides B/D low, A/C tristate, force on
    apb(1'b1, `CG_ADDR_CON0, 32'h0);
    for (int a = `CG_ADDR_CNT0; a <= `CG_ADDR_CNTN; a += 4) apb(1'b1, 8'(a), 32'h0);
    apb(1'b1, `CG_ADDR_SDSRC, 32'h2);
    apb(1'b1, `CG_ADDR_SDCTL, 32'h87);
    apb(1'b1, `CG_ADDR_STEER, 32'h0F);
    apb(1'b1, `CG_ADDR_CON1, 32'hC5);
    apb(1'b1, `CG_ADDR_CON0, 32'h88);
    apb(1'b0, `CG_ADDR_CON0, 32'h0); check("con0 on", rd, 32'h88);
    waitEnable(4'hA);
    check("override low", {28'h0, outLevel & 4'hA}, 32'h0);
    check("pin low", {28'h0, pinLevel & 4'hA}, 32'h0);
    apb(1'b1, `CG_ADDR_SDCTL, 32'h07);
    repeat (10) @(posedge clk);
    check("held override", {28'h0, outEnable}, 32'hA);
    pulseEvents(4'hA);
    waitEnable(4'hF);
    check("idle level", {28'h0, pinLevel}, 32'h5);
    $display("test start done");
    // external fault, then auto restart
    faultOn <= 4'h2;
    waitEnable(4'hA);
    apb(1'b1, `CG_ADDR_SDCTL, 32'hC7);
    faultOn <= 4'h0;
    n = 0;
    do begin
      apb(1'b0, `CG_ADDR_SDCTL, 32'h0);
      n++;
    end while (rd[7] !== 1'b0 && n < 20);
    check("force cleared", {31'h0, rd[7]}, 32'h0);
    check("held override", {28'h0, outEnable}, 32'hA);
    pulseEvents(4'hA);
    waitEnable(4'hF);
    $display("test restart done");
    // buffer load waits for the next event, then reads zero
    apb(1'b1, `CG_ADDR_CNT0, ($urandom & 32'hFFFF_FF00) | 32'h3);
    apb(1'b1, `CG_ADDR_CON0, 32'hC8);
    apb(1'b0, `CG_ADDR_CON0, 32'h0); check("load pending", rd, 32'hC8);
    pulseEvents(4'hA);
    n = 0;
    do begin
      apb(1'b0, `CG_ADDR_CON0, 32'h0);
      n++;
    end while (rd[6] !== 1'b0 && n < 20);
    check("load done", rd, 32'h88);
    // half bridge on the quarter-rate clock, now with the loaded three-tick rising phase
    apb(1'b1, `CG_ADDR_CON0, 32'h84);
    pulseEvents(4'h0);
    check("half idle level", {28'h0, outLevel}, 32'hF);
    apb(1'b1, `CG_ADDR_CON0, 32'h08);
    waitEnable(4'h0);
    $display("test load done");
    wrap_up();
  end
endmodule
`default_nettype wire
